/* axcs_defines.svh */
// Register offsets, field positions, reset values and codes for the aux config bank
`ifndef AXCS_DEFINES_SVH
`define AXCS_DEFINES_SVH

`define AXCS_ADDR_CH8_SETUP    8'h2f
`define AXCS_ADDR_CLK_SRC      8'h32

`define AXCS_CH8_RST           8'h07
`define AXCS_CLK_SRC_RST       8'h00

`define AXCS_CH8_SRC_MSB       6
`define AXCS_CH8_SRC_LSB       5
`define AXCS_CH8_SLOT_MSB      4
`define AXCS_CH8_SLOT_LSB      0
`define AXCS_PREDIV_MSB        7
`define AXCS_PREDIV_LSB        6
`define AXCS_BCLKDIV_MSB       5
`define AXCS_BCLKDIV_LSB       3
`define AXCS_CH8_RSVD_BIT      7
`define AXCS_CLK_RSVD_MSB      2
`define AXCS_CLK_RSVD_LSB      0

`define AXCS_SRC_RST           2'h0
`define AXCS_SLOT_RST          5'h07
`define AXCS_PREDIV_RST        2'h0
`define AXCS_BCLKDIV_RST       3'h0

`define AXCS_HALF_SLOTS        5'h10

`endif

/* axcs_pkg.sv */
// Types shared by the aux config bank
package axcs_pkg;

  typedef enum logic [1:0] {
    axcs_src_off,
    axcs_src_playback,
    axcs_src_loopback,
    axcs_src_link
  } axcs_ch8_src_e;

  typedef enum logic [1:0] {
    axcs_fmt_tdm,
    axcs_fmt_i2s,
    axcs_fmt_lj
  } axcs_format_e;

  typedef struct packed {
    logic [1:0] prediv_source_select;
    logic [2:0] main_port_bitclk_div_source;
  } axcs_clk_sel_s;

  typedef struct packed {
    logic       active;
    logic       right_half;
    logic [4:0] slot_index;
  } axcs_slot_match_s;

endpackage

/* axcs_slot_map.sv */
// Maps the channel-8 slot number onto a frame slot for the current framing
`timescale 1ns/1ps
`include "axcs_defines.svh"

module axcs_slot_map (
  // Settings
  input  wire logic [1:0]          ch8_source_field,
  input  wire logic [4:0]          ch8_slot_number,
  input  wire axcs_pkg::axcs_format_e format,
  // Mapped slot
  output axcs_pkg::axcs_slot_match_s match
);

  always_comb begin
    match.active     = (axcs_pkg::axcs_ch8_src_e'(ch8_source_field) != axcs_pkg::axcs_src_off);
    match.right_half = 1'b0;
    match.slot_index = 5'h00;
    if (!match.active) begin
      match.slot_index = 5'h00;
    end else if (format == axcs_pkg::axcs_fmt_tdm) begin
      match.slot_index = ch8_slot_number;
    end else begin
      match.right_half = (ch8_slot_number >= `AXCS_HALF_SLOTS);
      match.slot_index = {1'b0, ch8_slot_number[3:0]};
    end
  end

endmodule

/* axcs_regs.sv */
// Channel-8 receive setup and clock source select registers
`timescale 1ns/1ps
`include "axcs_defines.svh"

module axcs_regs (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   srst,
  // Control port register access
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  // Frame context from the secondary serial port
  input  wire axcs_pkg::axcs_format_e  frame_format,
  input  wire logic                   slot_strobe,
  input  wire logic                   slot_right,
  input  wire logic [4:0]             slot_index,
  input  wire logic [31:0]            slot_data,
  // Channel 8 settings and captured data
  output logic      [1:0]             ch8_source_field,
  output logic      [4:0]             ch8_slot_number,
  output logic                        ch8_valid,
  output logic      [31:0]            ch8_data,
  // Clock source selects
  output axcs_pkg::axcs_clk_sel_s      clk_sel
);

  // Settings group
  logic [1:0]                 src_q;
  logic [1:0]                 src_d;
  logic [4:0]                 slot_q;
  logic [4:0]                 slot_d;
  axcs_pkg::axcs_clk_sel_s    clk_q;
  axcs_pkg::axcs_clk_sel_s    clk_d;

  // Read group
  logic [7:0]                 rdata_q;
  logic [7:0]                 rdata_d;

  // Capture group
  logic                       valid_q;
  logic                       valid_d;
  logic [31:0]                data_q;
  logic [31:0]                data_d;

  // Address decode
  logic                       wr_ch8;
  logic                       wr_clk;
  logic                       rd_ch8;
  logic                       rd_clk;

  // Readback words
  logic [7:0]                 ch8_word;
  logic [7:0]                 clk_word;

  // Slot match
  axcs_pkg::axcs_slot_match_s match;
  logic                       slot_eq;
  logic                       half_eq;
  logic                       hit;

  axcs_slot_map u_map (
    .ch8_source_field (src_q),
    .ch8_slot_number  (slot_q),
    .format           (frame_format),
    .match            (match)
  );

  // Address decode; offsets of neighbouring banks leave every strobe low
  always_comb begin
    wr_ch8 = 1'b0;
    wr_clk = 1'b0;
    rd_ch8 = 1'b0;
    rd_clk = 1'b0;

    case (reg_addr)
      `AXCS_ADDR_CH8_SETUP: begin
        wr_ch8 = reg_wr;
        rd_ch8 = reg_rd;
      end
      `AXCS_ADDR_CLK_SRC: begin
        wr_clk = reg_wr;
        rd_clk = reg_rd;
      end
      default: begin
        wr_ch8 = 1'b0;
        rd_ch8 = 1'b0;
      end
    endcase
  end

  // Settings: next values
  always_comb begin
    src_d  = src_q;
    slot_d = slot_q;
    clk_d  = clk_q;

    // Bit 7 has no storage, so a stray one written there never reads back
    if (wr_ch8) begin
      src_d  = reg_wdata[`AXCS_CH8_SRC_MSB:`AXCS_CH8_SRC_LSB];
      slot_d = reg_wdata[`AXCS_CH8_SLOT_MSB:`AXCS_CH8_SLOT_LSB];
    end

    // Bits 2-0 have no storage either
    if (wr_clk) begin
      clk_d.prediv_source_select =
        reg_wdata[`AXCS_PREDIV_MSB:`AXCS_PREDIV_LSB];
      // Reserved codes are stored as written; steering them is software's hazard
      clk_d.main_port_bitclk_div_source =
        reg_wdata[`AXCS_BCLKDIV_MSB:`AXCS_BCLKDIV_LSB];
    end
  end

  // Settings: registers
  always_ff @(posedge clock) begin
    if (srst) begin
      src_q                             <= `AXCS_SRC_RST;
      slot_q                            <= `AXCS_SLOT_RST;
      clk_q.prediv_source_select        <= `AXCS_PREDIV_RST;
      clk_q.main_port_bitclk_div_source <= `AXCS_BCLKDIV_RST;
    end else begin
      src_q  <= src_d;
      slot_q <= slot_d;
      clk_q  <= clk_d;
    end
  end

  // Readback words; reserved bits are tied low here rather than stored
  always_comb begin
    // Channel-8 setup word
    ch8_word = 8'h00;
    ch8_word[`AXCS_CH8_SRC_MSB:`AXCS_CH8_SRC_LSB]   = src_q;
    ch8_word[`AXCS_CH8_SLOT_MSB:`AXCS_CH8_SLOT_LSB] = slot_q;
    ch8_word[`AXCS_CH8_RSVD_BIT]                    = 1'b0;

    // Clock source word
    clk_word = 8'h00;
    clk_word[`AXCS_PREDIV_MSB:`AXCS_PREDIV_LSB]     = clk_q.prediv_source_select;
    clk_word[`AXCS_BCLKDIV_MSB:`AXCS_BCLKDIV_LSB]   = clk_q.main_port_bitclk_div_source;
    clk_word[`AXCS_CLK_RSVD_MSB:`AXCS_CLK_RSVD_LSB] = 3'h0;
  end

  // Read data: next value; held between reads so software may sample late
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      // Unmapped offsets read as zero
      rdata_d = 8'h00;
      if (rd_ch8) begin
        rdata_d = ch8_word;
      end
      if (rd_clk) begin
        rdata_d = clk_word;
      end
    end
  end

  // Read data: register; a write in the same cycle is not yet visible here
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Capture: next values
  always_comb begin
    slot_eq = (slot_index == match.slot_index);
    half_eq = (slot_right == match.right_half);
    hit     = 1'b0;
    if (match.active && slot_strobe) begin
      case (frame_format)
        axcs_pkg::axcs_fmt_tdm: begin
          hit = slot_eq;
        end
        default: begin
          // I2S and left-justified framing split the slots into two halves
          hit = slot_eq && half_eq;
        end
      endcase
    end

    // A disabled channel never hits, so its last word simply stays put
    valid_d = hit;
    data_d  = data_q;
    if (hit) begin
      data_d = slot_data;
    end
  end

  // Capture: registers
  always_ff @(posedge clock) begin
    if (srst) begin
      valid_q <= 1'b0;
      data_q  <= 32'h0000_0000;
    end else begin
      valid_q <= valid_d;
      data_q  <= data_d;
    end
  end

  // Outputs, each straight from its register
  assign reg_rdata        = rdata_q;
  assign ch8_source_field = src_q;
  assign ch8_slot_number  = slot_q;
  assign ch8_valid        = valid_q;
  assign ch8_data         = data_q;
  assign clk_sel          = clk_q;

endmodule

/* axcs_regs_properties.sv */
// Port checks for the aux config bank
`timescale 1ns/1ps
module axcs_regs_chk (
  // Clock, reset and register access
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Capture side and settings
  input wire axcs_pkg::axcs_format_e frame_format,
  input wire logic slot_strobe,
  input wire logic slot_right,
  input wire logic [4:0] slot_index,
  input wire logic [1:0] ch8_source_field,
  input wire logic [4:0] ch8_slot_number,
  input wire logic ch8_valid,
  input wire axcs_pkg::axcs_clk_sel_s clk_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Settings are those in force at the strobe edge, not any write landing with it
  wire on = slot_strobe && ch8_source_field != 2'h0;
  wire w2f = reg_wr && reg_addr == 8'h2f;
  wire w32 = reg_wr && reg_addr == 8'h32;
  a_ch8_readback: assert property (reg_rd && reg_addr == 8'h2f |=>
    reg_rdata == {1'b0, $past(ch8_source_field), $past(ch8_slot_number)}) else $error("ch8 read");
  a_clk_readback: assert property (reg_rd && reg_addr == 8'h32 |=>
    reg_rdata == {$past(clk_sel), 3'h0}) else $error("clk read");
  a_ch8_write: assert property (w2f |=> {ch8_source_field, ch8_slot_number}
    == $past(reg_wdata[6:0])) else $error("ch8 write");
  a_prediv_write: assert property (w32 |=> clk_sel[4:3] == $past(reg_wdata[7:6]))
    else $error("prediv write");
  a_bclk_write: assert property (w32 |=> clk_sel[2:0] == $past(reg_wdata[5:3]))
    else $error("bclk write");
  a_tdm_pick: assert property (on && frame_format == axcs_pkg::axcs_fmt_tdm
    && slot_index == ch8_slot_number |=> ch8_valid) else $error("tdm pick");
  a_half_pick: assert property (on && frame_format != axcs_pkg::axcs_fmt_tdm
    && {slot_right, slot_index} == {ch8_slot_number[4], 1'b0, ch8_slot_number[3:0]}
    |=> ch8_valid) else $error("half pick");
  a_off_quiet: assert property (ch8_source_field == 2'h0 |=> !ch8_valid)
    else $error("off capture");
endmodule
bind axcs_regs axcs_regs_chk u_chk (.clock, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .frame_format, .slot_strobe, .slot_right, .slot_index, .ch8_source_field,
  .ch8_slot_number, .ch8_valid, .clk_sel);

/* tb_axcs_regs.sv */
// Self-checking bench for the aux config bank
`timescale 1ns/1ps
module tb_axcs_regs;
  logic clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic slot_strobe = 1'b0, slot_right = 1'b0;
  logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata;
  logic [4:0] slot_index = 5'h0, ch8_slot_number;
  logic [31:0] slot_data = 32'h0, ch8_data, last = 32'h0;
  logic [1:0] ch8_source_field;
  logic ch8_valid;
  axcs_pkg::axcs_format_e frame_format = axcs_pkg::axcs_fmt_tdm;
  axcs_pkg::axcs_clk_sel_s clk_sel;
  int err_count = 0, n_checks = 0;
  // Address, write data, expected read back; the last row is unmapped
  // Reserved bits are written as zero and reserved divider codes never
  logic [23:0] rows [11] = '{24'h2f7f7f, 24'h2f4a4a, 24'h2f2525, 24'h2f5f5f, 24'h32c0c0,
    24'h32e8e8, 24'h326060, 24'h329898, 24'h320000, 24'h321010, 24'h30ff00};
  always #5 clock = ~clock;
  axcs_regs dut (.clock, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .frame_format, .slot_strobe, .slot_right, .slot_index, .slot_data, .ch8_source_field,
    .ch8_slot_number, .ch8_valid, .ch8_data, .clk_sel);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(negedge clock);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clock);
    {reg_wr, reg_rd} = 2'h0;
  endtask
  // Data changes every slot so a stale capture cannot pass
  task automatic cap(logic [1:0] f, logic r, logic [4:0] i, logic v);
    @(negedge clock);
    frame_format = axcs_pkg::axcs_format_e'(f);
    {slot_strobe, slot_right, slot_index} = {1'b1, r, i};
    slot_data = slot_data + 32'h01230001;
    @(negedge clock);
    slot_strobe = 1'b0;
    if (v) last = slot_data;
    chk("ch8_valid", v, ch8_valid);
    chk("ch8_data", last, ch8_data);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    srst = 1'b0;
    foreach (rows[k]) begin
      acc(1'b1, rows[k][23:16], rows[k][15:8]);
      acc(1'b0, rows[k][23:16], 8'h00);
      chk("reg_rdata", rows[k][7:0], reg_rdata);
    end
    chk("clk_sel", 5'h02, clk_sel);
    acc(1'b1, 8'h2f, 8'h7f);
    chk("ch8_source_field", 2'h3, ch8_source_field);
    chk("ch8_slot_number", 5'h1f, ch8_slot_number);
    cap(2'h0, 1'b0, 5'h1f, 1'b1);
    cap(2'h0, 1'b0, 5'h1e, 1'b0);
    cap(2'h1, 1'b1, 5'h0f, 1'b1);
    cap(2'h2, 1'b0, 5'h0f, 1'b0);
    acc(1'b1, 8'h2f, 8'h20);
    cap(2'h2, 1'b0, 5'h00, 1'b1);
    cap(2'h1, 1'b1, 5'h00, 1'b0);
    acc(1'b1, 8'h2f, 8'h00);
    cap(2'h0, 1'b0, 5'h00, 1'b0);
    acc(1'b1, 8'h32, 8'he8);
    chk("clk_sel", 5'h1d, clk_sel);
    acc(1'b1, 8'h2f, 8'h45);
    srst = 1'b1;
    @(negedge clock);
    srst = 1'b0;
    chk("clk_sel", 5'h00, clk_sel);
    chk("ch8_source_field", 2'h0, ch8_source_field);
    chk("ch8_slot_number", 5'h07, ch8_slot_number);
    acc(1'b0, 8'h2f, 8'h00);
    chk("reg_rdata", 8'h07, reg_rdata);
    report_and_stop;
  end
endmodule
